// file: design/kpc_keyscan_port.sv
// kpc_keyscan_port: key-matrix scanner, debouncer and port block.
// assumes the serial engine presents one register access at a time
// on its own clock, and the display logic supplies intensity and the
// segment level for the shared pin.
`timescale 1ns/100ps

module kpc_keyscan_port
  import kpc_pkg::*;
#(
  parameter int SLOT_CYCLES = kpc_pkg::KPC_SLOT_CYCLES,
  parameter int DEB_ROUNDS = kpc_pkg::KPC_DEB_ROUNDS
)
(
  input wire logic i_clk, // core clock, 50 MHz
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_link_clk, // serial engine clock
  input wire logic i_req, // link: access request pulse
  input wire logic i_req_wr, // link: 1 write, 0 read
  input wire logic [7:0] i_req_addr, // link: register address
  input wire logic [7:0] i_req_wdata, // link: write data
  output logic o_link_busy, // link: access in flight
  output logic o_rdata_valid, // link: answer pulse
  output logic [7:0] o_rdata, // link: read data
  input wire logic [5:0] i_intensity, // pwm setting from display logic
  input wire logic i_seg_level, // segment level when pin is a segment
  input wire logic i_first_input_port, // pin, pulled up
  input wire logic i_second_input_port, // pin, pulled up
  output logic [3:0] o_cathode_strobe_n, // digit strobes, low active
  output logic o_shared_pin_out, // shared pin output level
  output logic o_shared_pin_oe_n // shared pin enable, low drives
);
  import kpc_pkg::*;

  localparam int SLOT_W = $clog2(SLOT_CYCLES + 1);
  localparam int ROUND_W = $clog2(DEB_ROUNDS + 1);
  localparam int STEP_CYCLES = SLOT_CYCLES / KPC_PWM_STEPS;
  localparam logic [ROUND_W-1:0] HALF_ROUND = ROUND_W'(DEB_ROUNDS / 2);
  localparam logic [ROUND_W-1:0] LAST_ROUND = ROUND_W'(DEB_ROUNDS - 1);
  localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(SLOT_CYCLES - 1);

  // ==========================================================
  // link domain: request capture and answer
  kpc_link_state_t link_state_reg;
  logic req_tgl_reg;
  logic req_wr_reg;
  logic [7:0] req_addr_reg;
  logic [7:0] req_wdata_reg;
  logic ack_s1_reg, ack_s2_reg, ack_s3_reg;
  logic ack_tgl_reg;
  logic [7:0] core_rdata_reg;

  // ack toggle synchroniser, first stage feeds only the second
  always_ff @(posedge i_link_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
    end
    else
    begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
    end
  end

  // one access in flight; fields stay frozen until the core answers
  always_ff @(posedge i_link_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      link_state_reg <= KPC_LINK_IDLE;
      req_tgl_reg <= 1'b0;
      req_wr_reg <= 1'b0;
      req_addr_reg <= 8'h00;
      req_wdata_reg <= 8'h00;
      o_link_busy <= 1'b0;
      o_rdata_valid <= 1'b0;
      o_rdata <= 8'h00;
    end
    else
    begin
      o_rdata_valid <= 1'b0;
      case (link_state_reg)
        KPC_LINK_IDLE:
        begin
          if (i_req)
          begin
            req_wr_reg <= i_req_wr;
            req_addr_reg <= i_req_addr;
            req_wdata_reg <= i_req_wdata;
            req_tgl_reg <= ~req_tgl_reg;
            o_link_busy <= 1'b1;
            link_state_reg <= KPC_LINK_WAIT;
          end
        end
        KPC_LINK_WAIT:
        begin
          if (ack_s2_reg != ack_s3_reg)
          begin
            o_rdata <= core_rdata_reg; // stable: core holds it until next request
            o_rdata_valid <= 1'b1;
            o_link_busy <= 1'b0;
            link_state_reg <= KPC_LINK_IDLE;
          end
        end
        default: link_state_reg <= KPC_LINK_IDLE;
      endcase
    end
  end

  // ==========================================================
  // core domain: request synchroniser and pin synchronisers
  logic req_s1_reg, req_s2_reg, req_s3_reg;
  logic [1:0] port_s1_reg, port_s2_reg;
  logic acc_stb;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      port_s1_reg <= 2'h3;
      port_s2_reg <= 2'h3;
    end
    else
    begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      port_s1_reg <= {i_second_input_port, i_first_input_port};
      port_s2_reg <= port_s1_reg;
    end
  end

  assign acc_stb = req_s2_reg ^ req_s3_reg;

  // ==========================================================
  // registers and register access
  logic [4:0] cfg_reg; // role and port modes
  logic [1:0] limit_reg;
  logic [7:0] debounced_reg;
  logic [7:0] pressed_reg;
  logic irq_pending_reg;
  logic deb_read;
  logic [7:0] newly_debounced;
  logic debounce_event;
  logic [7:0] port_cfg_view;

  assign deb_read = acc_stb && !req_wr_reg && (req_addr_reg == KPC_ADDR_DEBOUNCED);

  // readback layout of the port configuration register
  always_comb
  begin
    port_cfg_view = {cfg_reg, port_s2_reg[1], port_s2_reg[0], irq_pending_reg};
  end

  // writes: only the config and scan limit hold data
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cfg_reg <= KPC_CFG_RESET;
      limit_reg <= KPC_LIMIT_RESET;
    end
    else if (acc_stb && req_wr_reg)
    begin
      if (req_addr_reg == KPC_ADDR_PORT_CFG)
        cfg_reg <= req_wdata_reg[KPC_ROLE_MSB:KPC_SCAN1_BIT];
      else if (req_addr_reg == KPC_ADDR_SCAN_LIMIT)
        limit_reg <= req_wdata_reg[1:0];
      // writes to the key registers fall through untouched
    end
  end

  // read data and answer toggle; unmapped addresses read zero
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      core_rdata_reg <= 8'h00;
      ack_tgl_reg <= 1'b0;
    end
    else if (acc_stb)
    begin
      ack_tgl_reg <= ~ack_tgl_reg;
      if (req_wr_reg)
        core_rdata_reg <= 8'h00;
      else
        case (req_addr_reg)
          KPC_ADDR_SCAN_LIMIT: core_rdata_reg <= {6'h00, limit_reg};
          KPC_ADDR_PORT_CFG: core_rdata_reg <= port_cfg_view;
          KPC_ADDR_DEBOUNCED: core_rdata_reg <= debounced_reg;
          KPC_ADDR_PRESSED: core_rdata_reg <= pressed_reg;
          default: core_rdata_reg <= 8'h00;
        endcase
    end
  end

  // ==========================================================
  // multiplex strobe timing
  logic [SLOT_W-1:0] slot_cnt_reg;
  logic [1:0] digit_reg;
  logic [ROUND_W-1:0] round_reg;
  logic [SLOT_W-1:0] low_cycles;
  logic slot_end;
  logic sample_now;

  // low time scales from 1/64 to 63/64 of the slot; the top two settings
  // share 63/64 so one step of blanking always parts adjacent strobes
  assign low_cycles = SLOT_W'(STEP_CYCLES * ((&i_intensity) ? KPC_PWM_STEPS - 1
                                                              : int'(i_intensity) + 1));
  assign slot_end = (slot_cnt_reg == LAST_SLOT);
  // sample on the last low cycle, where the return line has settled longest
  assign sample_now = (slot_cnt_reg == low_cycles - SLOT_W'(1));

  // free-running scan: no host action needed to keep it going
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      slot_cnt_reg <= '0;
      digit_reg <= 2'h0;
      round_reg <= '0;
    end
    else if (slot_end)
    begin
      slot_cnt_reg <= '0;
      if (digit_reg >= limit_reg)
      begin
        digit_reg <= 2'h0;
        round_reg <= (round_reg == LAST_ROUND) ? '0 : round_reg + ROUND_W'(1);
      end
      else
        digit_reg <= digit_reg + 2'h1;
    end
    else
      slot_cnt_reg <= slot_cnt_reg + SLOT_W'(1);
  end

  // strobe of the active digit is low for the pwm share of its slot
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_cathode_strobe_n <= 4'hF;
    else
    begin
      o_cathode_strobe_n <= 4'hF;
      if (slot_cnt_reg < low_cycles)
        o_cathode_strobe_n[digit_reg] <= 1'b0;
    end
  end

  // ==========================================================
  // sampling and debouncing
  logic [7:0] sample_a_reg;
  logic [7:0] sample_b_reg;
  logic [7:0] last_pass_reg;
  logic [7:0] key_enable;
  logic phase_a;
  logic pass_end;

  // two keys per enabled digit, and only on ports set to scan
  always_comb
  begin
    for (int k = 0; k < KPC_DIGITS; k++)
    begin
      key_enable[k] = cfg_reg[KPC_SCAN1_BIT - KPC_SCAN1_BIT] && (k <= int'(limit_reg));
      key_enable[k + KPC_DIGITS] = cfg_reg[KPC_SCAN2_BIT - KPC_SCAN1_BIT]
                                   && (k <= int'(limit_reg));
    end
  end

  assign phase_a = (round_reg < HALF_ROUND);
  assign pass_end = slot_end && (digit_reg >= limit_reg) && (round_reg == LAST_ROUND);

  // each key sampled once in each half of the pass; pressed reads low
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sample_a_reg <= 8'h00;
      sample_b_reg <= 8'h00;
      pressed_reg <= 8'h00;
    end
    else
    begin
      if (sample_now && (round_reg == '0 || round_reg == HALF_ROUND))
      begin
        if (phase_a)
        begin
          sample_a_reg[digit_reg] <= !port_s2_reg[0];
          sample_a_reg[{1'b1, digit_reg}] <= !port_s2_reg[1];
        end
        else
        begin
          sample_b_reg[digit_reg] <= !port_s2_reg[0];
          sample_b_reg[{1'b1, digit_reg}] <= !port_s2_reg[1];
        end
        pressed_reg[digit_reg] <= !port_s2_reg[0] && key_enable[digit_reg];
        pressed_reg[{1'b1, digit_reg}] <= !port_s2_reg[1]
                                          && key_enable[{1'b1, digit_reg}];
      end
      if (pass_end)
        pressed_reg <= pressed_reg & key_enable; // drop keys just disabled
    end
  end

  // every key judged on its own, so any mix of keys counts
  assign newly_debounced = sample_a_reg & sample_b_reg & key_enable
                           & ~last_pass_reg;
  assign debounce_event = pass_end && (newly_debounced != 8'h00);

  // memory of keys held through the last pass blocks repeat reports
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      last_pass_reg <= 8'h00;
    else if (pass_end)
      last_pass_reg <= sample_a_reg & sample_b_reg & key_enable;
  end

  // accumulating flags; a new event beats the read clear
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      debounced_reg <= 8'h00;
    else
      debounced_reg <= (deb_read ? 8'h00 : debounced_reg)
                       | (pass_end ? newly_debounced : 8'h00);
  end

  // pending interrupt: set by a debounce event, cleared by the flag read
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      irq_pending_reg <= 1'b0;
    else if (debounce_event)
      irq_pending_reg <= 1'b1;
    else if (deb_read)
      irq_pending_reg <= 1'b0;
  end

  // ==========================================================
  // shared pin: open drain for logic and interrupt roles
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_shared_pin_out <= 1'b0;
      o_shared_pin_oe_n <= 1'b1;
    end
    else if (cfg_reg[KPC_ROLE_MSB - KPC_SCAN1_BIT])
    begin
      o_shared_pin_out <= i_seg_level;
      o_shared_pin_oe_n <= 1'b0;
    end
    else
    begin
      o_shared_pin_out <= 1'b0;
      case (cfg_reg[KPC_ROLE_MSB - KPC_SCAN1_BIT:KPC_ROLE_LSB - KPC_SCAN1_BIT])
        KPC_ROLE_LOW: o_shared_pin_oe_n <= 1'b0;
        KPC_ROLE_HIGH: o_shared_pin_oe_n <= 1'b1;
        KPC_ROLE_IRQ_LO: o_shared_pin_oe_n <= !irq_pending_reg;
        KPC_ROLE_IRQ_HI: o_shared_pin_oe_n <= irq_pending_reg;
        default: o_shared_pin_oe_n <= 1'b1;
      endcase
    end
  end

endmodule // kpc_keyscan_port

// file: design/kpc_pkg.sv
// kpc_pkg: constants shared by the key-scan and port controller.
// assumes a 50 MHz core clock and an 8-bit register space reached
// through the serial interface engine of the surrounding driver.
package kpc_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] KPC_ADDR_SCAN_LIMIT = 8'h03;
  localparam logic [7:0] KPC_ADDR_PORT_CFG = 8'h06;
  localparam logic [7:0] KPC_ADDR_DEBOUNCED = 8'h08;
  localparam logic [7:0] KPC_ADDR_PRESSED = 8'h0C;

  // ==========================================================
  // port_and_irq_config field layout
  localparam int KPC_ROLE_MSB = 7;
  localparam int KPC_ROLE_LSB = 5;
  localparam int KPC_SCAN2_BIT = 4;
  localparam int KPC_SCAN1_BIT = 3;
  localparam int KPC_LVL2_BIT = 2;
  localparam int KPC_LVL1_BIT = 1;
  localparam int KPC_IRQ_BIT = 0;

  // shared pin roles (top bit set means segment driver)
  localparam logic [2:0] KPC_ROLE_LOW = 3'h0;
  localparam logic [2:0] KPC_ROLE_HIGH = 3'h1;
  localparam logic [2:0] KPC_ROLE_IRQ_LO = 3'h2;
  localparam logic [2:0] KPC_ROLE_IRQ_HI = 3'h3;

  // ==========================================================
  // reset values
  localparam logic [4:0] KPC_CFG_RESET = 5'h10; // segment role, logic inputs
  localparam logic [1:0] KPC_LIMIT_RESET = 2'h3;

  // ==========================================================
  // timing
  localparam int KPC_CLK_PERIOD_NS = 20;
  localparam int KPC_SLOT_TIME_NS = 320000;
  localparam int KPC_SLOT_CYCLES = KPC_SLOT_TIME_NS / KPC_CLK_PERIOD_NS;
  localparam int KPC_PWM_STEPS = 64;
  localparam int KPC_DEBOUNCE_TIME_NS = 41000000;
  localparam int KPC_DIGITS = 4;
  localparam int KPC_DEB_ROUNDS = KPC_DEBOUNCE_TIME_NS / (KPC_SLOT_TIME_NS * KPC_DIGITS);

  // host-side request handshake states
  typedef enum logic {KPC_LINK_IDLE, KPC_LINK_WAIT} kpc_link_state_t;

endpackage

// file: bench/kpc_keyscan_assertions.sv
// kpc_keyscan_assertions: port-level checks of the key-scan block.
// assumes binding to kpc_keyscan_port, slot length passed on.
`timescale 1ns/100ps
module kpc_keyscan_assertions
#(
  parameter int SLOT_CYCLES = 128
)
(
  input wire logic i_clk, // core clock
  input wire logic i_reset_n, // async reset, low
  input wire logic i_link_clk, // link clock
  input wire logic i_req, // link request
  input wire logic o_link_busy, // access in flight
  input wire logic o_rdata_valid, // answer pulse
  input wire logic [7:0] o_rdata, // read data
  input wire logic [3:0] o_cathode_strobe_n, // strobes
  input wire logic o_shared_pin_out, // pin level
  input wire logic o_shared_pin_oe_n // pin enable, low drives
);
  // ==========================================================
  // helper logic
  localparam int MAX_LOW = (SLOT_CYCLES / 64) * 63;
  logic [15:0] low_cnt;
  logic [1:0] last_dig;
  logic [1:0] cur_dig;
  // index of the low strobe, zero when none is low
  always_comb
  begin
    cur_dig = 2'h0;
    for (int d = 0; d < 4; d++)
      if (!o_cathode_strobe_n[d]) cur_dig = 2'(d);
  end
  // length of the current low stretch; a full slot low is never legal
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) low_cnt <= 16'h0000;
    else low_cnt <= (&o_cathode_strobe_n) ? 16'h0000 : low_cnt + 16'h0001;
  // last digit strobed, to check the rotation
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) last_dig <= 2'h3;
    else if (!(&o_cathode_strobe_n)) last_dig <= cur_dig;
  // ==========================================================
  // link handshake
  sequence s_take;
    i_req && !o_link_busy;
  endsequence
  sequence s_answer;
    ##[1:12] o_rdata_valid;
  endsequence
  property p_answer;
    @(posedge i_link_clk) disable iff (!i_reset_n) s_take |-> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer to access");
  property p_busy;
    @(posedge i_link_clk) disable iff (!i_reset_n) s_take |=> o_link_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
  property p_valid;
    @(posedge i_link_clk) disable iff (!i_reset_n)
      o_rdata_valid |-> !o_link_busy ##1 !o_rdata_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("answer pulse malformed");
  property p_hold;
    @(posedge i_link_clk) disable iff (!i_reset_n) !o_rdata_valid |-> $stable(o_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // ==========================================================
  // scanning and shared pin
  property p_one;
    @(posedge i_clk) disable iff (!i_reset_n) $onehot0(~o_cathode_strobe_n);
  endproperty
  a_one: assert property (p_one) else $error("two strobes low");
  property p_len;
    @(posedge i_clk) disable iff (!i_reset_n) low_cnt <= 16'(MAX_LOW);
  endproperty
  a_len: assert property (p_len) else $error("strobe low too long");
  property p_order;
    @(posedge i_clk) disable iff (!i_reset_n)
      $fell(&o_cathode_strobe_n) |-> cur_dig == last_dig + 2'h1 || cur_dig == 2'h0;
  endproperty
  a_order: assert property (p_order) else $error("strobe out of turn");
  property p_scan;
    @(posedge i_clk) disable iff (!i_reset_n) 1'h1 |-> ##[0:600] !(&o_cathode_strobe_n);
  endproperty
  a_scan: assert property (p_scan) else $error("scanning stopped");
  property p_pin;
    @(posedge i_clk) disable iff (!i_reset_n) o_shared_pin_oe_n |-> !o_shared_pin_out;
  endproperty
  a_pin: assert property (p_pin) else $error("released pin drives");
endmodule // kpc_keyscan_assertions

bind kpc_keyscan_port kpc_keyscan_assertions #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_link_clk(i_link_clk),
  .i_req(i_req),
  .o_link_busy(o_link_busy),
  .o_rdata_valid(o_rdata_valid),
  .o_rdata(o_rdata),
  .o_cathode_strobe_n(o_cathode_strobe_n),
  .o_shared_pin_out(o_shared_pin_out),
  .o_shared_pin_oe_n(o_shared_pin_oe_n)
);

// file: bench/kpc_key_matrix.sv
// kpc_key_matrix: switch matrix on the strobes and return lines.
// assumes pulled-up return lines and one diode per key.
`timescale 1ns/100ps
module kpc_key_matrix
(
  input wire logic [7:0] i_keys_down, // keys held closed
  input wire logic [3:0] i_strobe_n, // cathode strobes
  output logic o_first_port, // return line, pulled up
  output logic o_second_port // return line, pulled up
);
  // a closed key pulls its line low only while its strobe is low
  assign o_first_port = ~|(i_keys_down[3:0] & ~i_strobe_n);
  assign o_second_port = ~|(i_keys_down[7:4] & ~i_strobe_n);
endmodule // kpc_key_matrix

// file: bench/tb.sv
// tb: register-level tests of the key-scan and port block.
// assumes short slots and passes; link clock free of the core clock.
`timescale 1ns/100ps
module tb;
  import kpc_pkg::*;
  localparam int TB_SLOT = 128;
  logic clk, lclk, rst_n, req, req_wr, seg;
  logic [5:0] intens;
  logic [7:0] addr, wdata, rd, keys;
  logic busy, valid, p1, p2, pin_out, oe_n;
  logic [7:0] rdata;
  logic [3:0] strobe_n;
  int failures, n_tests;
  // pin level with its pull-up
  wire pin_lvl = oe_n ? 1'h1 : pin_out;
  kpc_keyscan_port #(.SLOT_CYCLES(TB_SLOT), .DEB_ROUNDS(4)) dut (
    .i_clk(clk), .i_reset_n(rst_n), .i_link_clk(lclk), .i_req(req),
    .i_req_wr(req_wr), .i_req_addr(addr), .i_req_wdata(wdata),
    .o_link_busy(busy), .o_rdata_valid(valid), .o_rdata(rdata),
    .i_intensity(intens), .i_seg_level(seg), .i_first_input_port(p1),
    .i_second_input_port(p2), .o_cathode_strobe_n(strobe_n),
    .o_shared_pin_out(pin_out), .o_shared_pin_oe_n(oe_n));
  kpc_key_matrix km (.i_keys_down(keys), .i_strobe_n(strobe_n),
    .o_first_port(p1), .o_second_port(p2));
  // ==========================================================
  // clocks, unrelated in phase
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    lclk = 1'h0;
    #7;
    forever #24 lclk = ~lclk;
  end
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one access; request held one link cycle, answer taken with valid
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(negedge lclk);
    req = 1'h1;
    req_wr = wr;
    addr = a;
    wdata = d;
    @(negedge lclk);
    req = 1'h0;
    k = 0;
    while (valid !== 1'h1 && k < 20)
    begin
      @(negedge lclk);
      k++;
    end
    if (k == 20) chk("link answer", 8'h00, 8'h01);
    rd = rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
    acc(1'h0, a, 8'h00);
    chk(nm, rd, exp);
  endtask
  task automatic pinchk(input logic exp);
    repeat (4) @(negedge clk);
    chk("shared pin", {7'h00, pin_lvl}, {7'h00, exp});
  endtask
  // length of one strobe stretch; the first fall after the change may
  // belong to a stretch cut short by it, so the second one is measured
  task automatic lowchk(input logic [5:0] lvl, input int steps);
    int n;
    @(negedge clk);
    intens = lvl;
    @(negedge strobe_n[0]);
    @(negedge strobe_n[0]);
    n = 0;
    @(negedge clk);
    while (strobe_n[0] === 1'h0 && n < 255)
    begin
      n++;
      @(negedge clk);
    end
    chk("strobe low", 8'(n), 8'((TB_SLOT / KPC_PWM_STEPS) * steps));
  endtask
  // long enough for two whole debounce passes
  task automatic wt;
    repeat (5000) @(negedge clk);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard, well beyond the six waits and strobe checks of the tests
  initial
  begin
    #1000000;
    failures++;
    stop_test();
  end
  // ==========================================================
  // tests
  initial
  begin
    {rst_n, req, req_wr, seg, addr, wdata, keys, failures, n_tests} = '0;
    intens = 6'h20;
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    rdc(KPC_ADDR_PORT_CFG, {KPC_CFG_RESET, 3'h6}, "cfg reset");
    rdc(KPC_ADDR_SCAN_LIMIT, 8'h03, "limit reset");
    rdc(KPC_ADDR_DEBOUNCED, 8'h00, "flags reset");
    rdc(KPC_ADDR_PRESSED, 8'h00, "pressed reset");
    pinchk(1'h0);
    seg = 1'h1;
    pinchk(1'h1);
    $display("test reset done");
    acc(1'h1, KPC_ADDR_PORT_CFG, {KPC_ROLE_IRQ_LO, 2'h3, 3'h0});
    rdc(KPC_ADDR_PORT_CFG, {KPC_ROLE_IRQ_LO, 2'h3, 3'h6}, "cfg back");
    pinchk(1'h1);
    keys = 8'hA5;
    wt();
    rdc(KPC_ADDR_PRESSED, 8'hA5, "pressed");
    acc(1'h0, KPC_ADDR_PORT_CFG, 8'h00);
    chk("irq pending", rd & 8'hF9, {KPC_ROLE_IRQ_LO, 2'h3, 3'h1});
    pinchk(1'h0);
    rdc(KPC_ADDR_PRESSED, 8'hA5, "pressed again");
    pinchk(1'h0);
    rdc(KPC_ADDR_DEBOUNCED, 8'hA5, "flags");
    pinchk(1'h1);
    wt();
    rdc(KPC_ADDR_DEBOUNCED, 8'h00, "held key");
    pinchk(1'h1);
    acc(1'h1, KPC_ADDR_DEBOUNCED, 8'hFF);
    acc(1'h1, KPC_ADDR_PRESSED, 8'h00);
    rdc(KPC_ADDR_PRESSED, 8'hA5, "pressed write");
    rdc(KPC_ADDR_DEBOUNCED, 8'h00, "flags write");
    $display("test interrupt done");
    keys = 8'h00;
    wt();
    rdc(KPC_ADDR_PRESSED, 8'h00, "released");
    keys = 8'h01;
    wt();
    keys = 8'h80;
    wt();
    rdc(KPC_ADDR_DEBOUNCED, 8'h81, "accumulate");
    $display("test accumulate done");
    keys = 8'h00;
    acc(1'h1, KPC_ADDR_SCAN_LIMIT, 8'h01);
    acc(1'h1, KPC_ADDR_PORT_CFG, {KPC_ROLE_IRQ_HI, 2'h1, 3'h0});
    rdc(KPC_ADDR_SCAN_LIMIT, 8'h01, "limit back");
    pinchk(1'h0);
    keys = 8'hFF;
    wt();
    rdc(KPC_ADDR_PRESSED, 8'h03, "limited");
    pinchk(1'h1);
    rdc(KPC_ADDR_DEBOUNCED, 8'h03, "limited flags");
    pinchk(1'h0);
    $display("test scan limit done");
    acc(1'h1, KPC_ADDR_PORT_CFG, {KPC_ROLE_LOW, 5'h00});
    pinchk(1'h0);
    acc(1'h1, KPC_ADDR_PORT_CFG, {KPC_ROLE_HIGH, 5'h00});
    pinchk(1'h1);
    seg = 1'h0;
    acc(1'h1, KPC_ADDR_PORT_CFG, 8'hE0);
    pinchk(1'h0);
    $display("test roles done");
    lowchk(6'h3F, 63);
    lowchk(6'h3E, 63);
    lowchk(6'h00, 1);
    $display("test strobe width done");
    stop_test();
  end
endmodule // tb
